// ### ebr_pkg.sv
// How it works
// - Different-area read after read starts with an idle cycle when enabled.
// - Write directly after read starts with an idle cycle when enabled.
// - Read directly after write starts with an idle cycle when enabled.
// - Idle cycle lasts one or two states, picked by the length select.
// - After reset all idle insertion enables read as set.
// - Idle cycle shows next address, floats data, keeps every strobe high.
// - Buffered write: first state write only, internal access overlaps the rest.
// - Low request with release enabled in expanded mode gives acknowledge and floats bus.
// - Released bus: internal masters continue; external accesses wait for request withdrawal.
// - Standby entry requested while released waits until the outside request goes away.
// - Request-out enabled: drive request out low for pending access or standby.
// - Request input high ends release; acknowledge returns high.
// - Outside release request beats a simultaneous internal external access.
// - Released state floats address, data, chip selects and all strobes.
// - Highest priority requester is granted and keeps bus while granted.
// - CPU lowest priority; while awake it loses bus only at cycle boundaries, never mid-longword.
// - CPU keeps bus through a bit manipulation read-modify-write.
// - Sleeping CPU gives up the bus at once.
// - Transfer controller requests on activation, releases only between its phases.
// - Outside request reaches arbitration; release waits for current external cycle end.
// - Reset aborts any cycle and puts the controller in its reset state.
// - Request out may fall before acknowledge during internal arbitration.
package ebr_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int AREA_W = 3;
  localparam int NCS = 8;
  localparam int BE_W = 2;
  localparam int BE_HI = 1;
  localparam int BE_LO = 0;
  localparam int IDX_DIFF = 0;
  localparam int IDX_WAR = 1;
  localparam int IDX_RAW = 2;
  localparam logic [2:0] IDLE_EN_RST = 3'h7;
  localparam logic [1:0] IDLE_SHORT = 2'h1;
  localparam logic [1:0] IDLE_LONG = 2'h2;
  localparam logic [1:0] IDLE_LAST = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [AREA_W-1:0] AREA_RST = 3'h0;
  localparam logic [NCS-1:0] CS_OFF = 8'hFF;
  localparam logic [BE_W-1:0] BE_RST = 2'h0;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_TI = 6'h02,
    ST_T1 = 6'h04,
    ST_T2 = 6'h08,
    ST_ARB = 6'h10,
    ST_REL = 6'h20
  } ebr_state_e;
endpackage

// ### ebr_master_arb.sv
`timescale 1ns/100ps
`default_nettype none
module ebr_master_arb (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic cpu_req_i,
  input wire logic cpu_lock_i,
  input wire logic cpu_sleep_i,
  input wire logic dtc_req_i,
  input wire logic dtc_phase_i,
  input wire logic bound_i,
  output logic cpu_gnt_o,
  output logic dtc_gnt_o
);
  logic cpu_gnt_r;
  logic dtc_gnt_r;
  logic cpu_free_w;
  logic dtc_keep_w;
  logic dtc_take_w;
  logic dtc_gnt_nxt;
  logic cpu_gnt_nxt;

  // CPU yields at a cycle break outside a locked sequence, or at once when asleep
  assign cpu_free_w = !cpu_gnt_r || cpu_sleep_i || (bound_i && !cpu_lock_i);
  // Controller holds the bus inside a phase and until a cycle break
  assign dtc_keep_w = dtc_gnt_r && (dtc_req_i || dtc_phase_i || !bound_i);
  assign dtc_take_w = dtc_req_i && !dtc_gnt_r && cpu_free_w;
  assign dtc_gnt_nxt = dtc_keep_w || dtc_take_w;
  assign cpu_gnt_nxt = !dtc_gnt_nxt && (cpu_req_i || (cpu_gnt_r && cpu_lock_i));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_gnt_r <= 1'b0;
      dtc_gnt_r <= 1'b0;
    end else begin
      cpu_gnt_r <= cpu_gnt_nxt;
      dtc_gnt_r <= dtc_gnt_nxt;
    end
  end

  assign cpu_gnt_o = cpu_gnt_r;
  assign dtc_gnt_o = dtc_gnt_r;
endmodule // ebr_master_arb
`default_nettype wire

// ### ebr_ext_bus_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
module ebr_ext_bus_arbiter (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic expanded_mode_i,
  input wire logic bus_release_en_i,
  input wire logic request_out_en_i,
  input wire logic write_buffer_en_i,
  input wire logic idle_length_sel_i,
  input wire logic idle_diff_area_read_en_i,
  input wire logic idle_write_after_read_en_i,
  input wire logic idle_read_after_write_en_i,
  input wire logic cpu_req_i,
  input wire logic cpu_lock_i,
  input wire logic cpu_sleep_i,
  input wire logic dtc_req_i,
  input wire logic dtc_phase_i,
  input wire logic standby_req_i,
  input wire logic xreq_i,
  input wire logic xwr_i,
  input wire logic [ebr_pkg::ADDR_W-1:0] xaddr_i,
  input wire logic [ebr_pkg::AREA_W-1:0] xarea_i,
  input wire logic [ebr_pkg::DATA_W-1:0] xwdata_i,
  input wire logic [ebr_pkg::BE_W-1:0] xbe_i,
  input wire logic ext_bus_request_in_n_i,
  output logic bus_ack_n_o,
  output logic bus_request_out_n_o,
  output logic [ebr_pkg::ADDR_W-1:0] addr_o,
  output logic addr_oe_o,
  output logic [ebr_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic [ebr_pkg::NCS-1:0] chip_select_n_o,
  output logic addr_strobe_n_o,
  output logic read_strobe_n_o,
  output logic high_write_strobe_n_o,
  output logic low_write_strobe_n_o,
  output logic ctrl_oe_o,
  output logic cpu_gnt_o,
  output logic dtc_gnt_o,
  output logic ext_done_o,
  output logic released_o,
  output logic standby_go_o
);
  // Reset and pin synchronisers
  logic rst_s1_r;
  logic rst_n;
  logic ext_bus_request_in_s1_r;
  logic ext_bus_request_in_s2_r;

  // Sequencer state
  ebr_pkg::ebr_state_e st_r;
  ebr_pkg::ebr_state_e st_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [2:0] cfg_idle_r;

  // Access being run on the pins
  logic [ebr_pkg::ADDR_W-1:0] cur_addr_r;
  logic [ebr_pkg::ADDR_W-1:0] cur_addr_nxt;
  logic [ebr_pkg::AREA_W-1:0] cur_area_r;
  logic [ebr_pkg::AREA_W-1:0] cur_area_nxt;
  logic [ebr_pkg::DATA_W-1:0] cur_wdata_r;
  logic [ebr_pkg::DATA_W-1:0] cur_wdata_nxt;
  logic [ebr_pkg::BE_W-1:0] cur_be_r;
  logic [ebr_pkg::BE_W-1:0] cur_be_nxt;
  logic cur_wr_r;
  logic cur_wr_nxt;
  logic cur_buf_r;
  logic cur_buf_nxt;

  // Previous external cycle
  logic last_vld_r;
  logic last_wr_r;
  logic [ebr_pkg::AREA_W-1:0] last_area_r;

  // Registered pin and status outputs
  logic ack_n_r;
  logic brqo_n_r;
  logic addr_oe_r;
  logic ctrl_oe_r;
  logic data_oe_r;
  logic [ebr_pkg::NCS-1:0] cs_n_r;
  logic as_n_r;
  logic rd_n_r;
  logic hwr_n_r;
  logic lwr_n_r;
  logic done_r;
  logic rel_r;
  logic stby_r;

  // Decodes
  logic cpu_gnt_w;
  logic dtc_gnt_w;
  logic acc_w;
  logic rel_req_w;
  logic start_w;
  logic need_idle_w;
  logic diff_rd_w;
  logic war_w;
  logic raw_w;
  logic bound_w;
  logic in_cyc_nxt;
  logic rel_nxt;
  logic done_nxt;
  logic brqo_nxt;
  logic [ebr_pkg::NCS-1:0] cs_hit_nxt;
  logic idle_st_w;
  logic t2_st_w;
  logic rd_n_nxt;
  logic hwr_n_nxt;
  logic lwr_n_nxt;
  logic doe_nxt;
  logic stby_nxt;

  // Decodes of the coming state shared by the pin and status stages
  function automatic logic ebr_in_cycle(input ebr_pkg::ebr_state_e s);
    ebr_in_cycle = (s == ebr_pkg::ST_T1) || (s == ebr_pkg::ST_T2);
  endfunction

  // Bus handed over, or being handed over, to the outside master
  function automatic logic ebr_bus_parked(input ebr_pkg::ebr_state_e s);
    ebr_bus_parked = (s == ebr_pkg::ST_ARB) || (s == ebr_pkg::ST_REL);
  endfunction

  // Async assert, two-flop release of the internal reset
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // Outside bus request pin passes two flops
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_bus_request_in_s1_r <= 1'b1;
      ext_bus_request_in_s2_r <= 1'b1;
    end else begin
      ext_bus_request_in_s1_r <= ext_bus_request_in_n_i;
      ext_bus_request_in_s2_r <= ext_bus_request_in_s1_r;
    end
  end

  ebr_master_arb u_arb (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .cpu_req_i(cpu_req_i),
    .cpu_lock_i(cpu_lock_i),
    .cpu_sleep_i(cpu_sleep_i),
    .dtc_req_i(dtc_req_i),
    .dtc_phase_i(dtc_phase_i),
    .bound_i(bound_w),
    .cpu_gnt_o(cpu_gnt_w),
    .dtc_gnt_o(dtc_gnt_w)
  );

  assign idle_st_w = (st_r == ebr_pkg::ST_IDLE);
  assign t2_st_w = (st_r == ebr_pkg::ST_T2);
  // Outside release request handed to arbitration
  // Release leaves only from IDLE, so a cycle already on the pins runs to its end
  assign rel_req_w = expanded_mode_i && bus_release_en_i && !ext_bus_request_in_s2_r;
  assign acc_w = xreq_i && (cpu_gnt_w || dtc_gnt_w);
  assign start_w = idle_st_w && !rel_req_w && acc_w;
  assign bound_w = t2_st_w || (idle_st_w && !acc_w);

  // Idle insertion conditions against the previous external cycle
  assign diff_rd_w = !xwr_i && !last_wr_r && (xarea_i != last_area_r)
    && cfg_idle_r[ebr_pkg::IDX_DIFF];
  assign war_w = xwr_i && !last_wr_r && cfg_idle_r[ebr_pkg::IDX_WAR];
  assign raw_w = !xwr_i && last_wr_r && cfg_idle_r[ebr_pkg::IDX_RAW];
  assign need_idle_w = last_vld_r && (diff_rd_w || war_w || raw_w);

  assign cur_addr_nxt = start_w ? xaddr_i : cur_addr_r;
  assign cur_area_nxt = start_w ? xarea_i : cur_area_r;
  assign cur_wdata_nxt = start_w ? xwdata_i : cur_wdata_r;
  assign cur_be_nxt = start_w ? xbe_i : cur_be_r;
  assign cur_wr_nxt = start_w ? xwr_i : cur_wr_r;
  assign cur_buf_nxt = start_w ? (write_buffer_en_i && xwr_i) : cur_buf_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ebr_pkg::ST_IDLE: begin
        cnt_nxt = idle_length_sel_i ? ebr_pkg::IDLE_LONG : ebr_pkg::IDLE_SHORT;
        if (rel_req_w) begin
          st_nxt = ebr_pkg::ST_ARB;
        end else if (acc_w) begin
          st_nxt = need_idle_w ? ebr_pkg::ST_TI : ebr_pkg::ST_T1;
        end
      end
      ebr_pkg::ST_TI: begin
        // Count down the idle states; a count of one marks the last
        cnt_nxt = cnt_r - 2'h1;
        if (cnt_r == ebr_pkg::IDLE_LAST) begin
          st_nxt = ebr_pkg::ST_T1;
        end
      end
      ebr_pkg::ST_T1: begin
        st_nxt = ebr_pkg::ST_T2;
      end
      ebr_pkg::ST_T2: begin
        st_nxt = ebr_pkg::ST_IDLE;
      end
      ebr_pkg::ST_ARB: begin
        st_nxt = rel_req_w ? ebr_pkg::ST_REL : ebr_pkg::ST_IDLE;
      end
      ebr_pkg::ST_REL: begin
        // Held here until the synchronised request pin is high again
        if (ext_bus_request_in_s2_r) begin
          st_nxt = ebr_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = ebr_pkg::ST_IDLE;
      end
    endcase
  end

  // Pin drive decodes from the coming state
  assign in_cyc_nxt = ebr_in_cycle(st_nxt);
  assign rel_nxt = (st_nxt == ebr_pkg::ST_REL);
  // Ready seen in the final state of the access, or in the first for a buffered write
  assign done_nxt = ((st_nxt == ebr_pkg::ST_T1) && cur_buf_nxt)
    || ((st_nxt == ebr_pkg::ST_T2) && !cur_buf_nxt);
  // Ask for the bus back while arbitrating or released
  assign brqo_nxt = request_out_en_i && ebr_bus_parked(st_nxt)
    && (acc_w || standby_req_i);
  assign doe_nxt = in_cyc_nxt && cur_wr_nxt;
  assign rd_n_nxt = !(in_cyc_nxt && !cur_wr_nxt);
  assign hwr_n_nxt = !(in_cyc_nxt && cur_wr_nxt && cur_be_nxt[ebr_pkg::BE_HI]);
  assign lwr_n_nxt = !(in_cyc_nxt && cur_wr_nxt && cur_be_nxt[ebr_pkg::BE_LO]);
  // Standby may go ahead only while the bus is ours
  assign stby_nxt = standby_req_i && !ebr_bus_parked(st_nxt);

  // One chip select per area, active only in T1 and T2
  genvar gi;
  generate
    for (gi = 0; gi < ebr_pkg::NCS; gi = gi + 1) begin : g_cs
      assign cs_hit_nxt[gi] = in_cyc_nxt && (int'(cur_area_nxt) == gi);
    end
  endgenerate

  // Sequencer and access capture; reset drops any cycle in flight
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ebr_pkg::ST_IDLE;
      cnt_r <= ebr_pkg::IDLE_SHORT;
      cfg_idle_r <= ebr_pkg::IDLE_EN_RST;
      cur_addr_r <= ebr_pkg::ADDR_RST;
      cur_area_r <= ebr_pkg::AREA_RST;
      cur_wdata_r <= ebr_pkg::DATA_RST;
      cur_be_r <= ebr_pkg::BE_RST;
      cur_wr_r <= 1'b0;
      cur_buf_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cfg_idle_r <= {idle_read_after_write_en_i, idle_write_after_read_en_i,
        idle_diff_area_read_en_i};
      cur_addr_r <= cur_addr_nxt;
      cur_area_r <= cur_area_nxt;
      cur_wdata_r <= cur_wdata_nxt;
      cur_be_r <= cur_be_nxt;
      cur_wr_r <= cur_wr_nxt;
      cur_buf_r <= cur_buf_nxt;
    end
  end

  // History of the last external cycle; forgotten over a release
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      last_vld_r <= 1'b0;
      last_wr_r <= 1'b0;
      last_area_r <= ebr_pkg::AREA_RST;
    end else if (st_r == ebr_pkg::ST_REL) begin
      last_vld_r <= 1'b0;
    end else if (t2_st_w) begin
      last_vld_r <= 1'b1;
      last_wr_r <= cur_wr_r;
      last_area_r <= cur_area_r;
    end
  end

  // Pin outputs
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_n_r <= 1'b1;
      brqo_n_r <= 1'b1;
      addr_oe_r <= 1'b1;
      ctrl_oe_r <= 1'b1;
      data_oe_r <= 1'b0;
      cs_n_r <= ebr_pkg::CS_OFF;
      as_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      hwr_n_r <= 1'b1;
      lwr_n_r <= 1'b1;
    end else begin
      ack_n_r <= !rel_nxt;
      brqo_n_r <= !brqo_nxt;
      addr_oe_r <= !rel_nxt;
      ctrl_oe_r <= !rel_nxt;
      data_oe_r <= doe_nxt;
      cs_n_r <= ~cs_hit_nxt;
      as_n_r <= !in_cyc_nxt;
      rd_n_r <= rd_n_nxt;
      hwr_n_r <= hwr_n_nxt;
      lwr_n_r <= lwr_n_nxt;
    end
  end

  // Status outputs
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      rel_r <= 1'b0;
      stby_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      rel_r <= rel_nxt;
      stby_r <= stby_nxt;
    end
  end

  assign bus_ack_n_o = ack_n_r;
  assign bus_request_out_n_o = brqo_n_r;
  assign addr_o = cur_addr_r;
  assign addr_oe_o = addr_oe_r;
  assign data_o = cur_wdata_r;
  assign data_oe_o = data_oe_r;
  assign chip_select_n_o = cs_n_r;
  assign addr_strobe_n_o = as_n_r;
  assign read_strobe_n_o = rd_n_r;
  assign high_write_strobe_n_o = hwr_n_r;
  assign low_write_strobe_n_o = lwr_n_r;
  assign ctrl_oe_o = ctrl_oe_r;
  assign cpu_gnt_o = cpu_gnt_w;
  assign dtc_gnt_o = dtc_gnt_w;
  assign ext_done_o = done_r;
  assign released_o = rel_r;
  assign standby_go_o = stby_r;
endmodule // ebr_ext_bus_arbiter
`default_nettype wire

// ### ebr_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ebr_monitor (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic expanded_mode_i,
  input wire logic bus_release_en_i,
  input wire logic request_out_en_i,
  input wire logic cpu_lock_i,
  input wire logic cpu_sleep_i,
  input wire logic dtc_req_i,
  input wire logic dtc_phase_i,
  input wire logic ext_bus_request_in_n_i,
  input wire logic bus_ack_n_o,
  input wire logic bus_request_out_n_o,
  input wire logic addr_oe_o,
  input wire logic data_oe_o,
  input wire logic ctrl_oe_o,
  input wire logic [ebr_pkg::NCS-1:0] chip_select_n_o,
  input wire logic addr_strobe_n_o,
  input wire logic read_strobe_n_o,
  input wire logic high_write_strobe_n_o,
  input wire logic low_write_strobe_n_o,
  input wire logic cpu_gnt_o,
  input wire logic dtc_gnt_o,
  input wire logic ext_done_o,
  input wire logic released_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  chk_float_released: assert property (released_o |-> !addr_oe_o && !data_oe_o && !ctrl_oe_o)
    else $error("Bus driven while released");
  chk_ack_floats: assert property ($fell(bus_ack_n_o) |-> !addr_oe_o && !ctrl_oe_o
    && bus_release_en_i && expanded_mode_i) else $error("Bad acknowledge");
  chk_ack_returns: assert property (ext_bus_request_in_n_i [*5] |-> bus_ack_n_o)
    else $error("Acknowledge stuck low");
  chk_no_cycle_rel: assert property (released_o |-> !ext_done_o)
    else $error("Cycle while released");
  chk_idle_quiet: assert property (addr_strobe_n_o && !released_o |->
    chip_select_n_o == ebr_pkg::CS_OFF && read_strobe_n_o && high_write_strobe_n_o
    && low_write_strobe_n_o && !data_oe_o) else $error("Strobe active when idle");
  chk_release_waits: assert property (ext_done_o |=> bus_ack_n_o [*2])
    else $error("Release too early");
  chk_req_out_gate: assert property (!bus_request_out_n_o |-> request_out_en_i)
    else $error("Request out not enabled");
  chk_grant_single: assert property (!(cpu_gnt_o && dtc_gnt_o))
    else $error("Two grants");
  chk_lock_keeps: assert property (cpu_gnt_o && cpu_lock_i && !cpu_sleep_i |=> cpu_gnt_o)
    else $error("Lost bus while locked");
  chk_sleep_yields: assert property (cpu_gnt_o && cpu_sleep_i && dtc_req_i |=> dtc_gnt_o)
    else $error("Sleeping cpu kept bus");
  chk_phase_keeps: assert property (dtc_gnt_o && dtc_req_i && dtc_phase_i |=> dtc_gnt_o)
    else $error("Lost bus in phase");
endmodule // ebr_monitor
bind ebr_ext_bus_arbiter ebr_monitor mon_u (.clk_sys_i, .rstn_i, .expanded_mode_i,
  .bus_release_en_i, .request_out_en_i, .cpu_lock_i, .cpu_sleep_i, .dtc_req_i, .dtc_phase_i,
  .ext_bus_request_in_n_i, .bus_ack_n_o, .bus_request_out_n_o, .addr_oe_o, .data_oe_o,
  .ctrl_oe_o, .chip_select_n_o, .addr_strobe_n_o, .read_strobe_n_o, .high_write_strobe_n_o,
  .low_write_strobe_n_o, .cpu_gnt_o, .dtc_gnt_o, .ext_done_o, .released_o);
`default_nettype wire

// ### ebr_outside_master.sv
`timescale 1ns/100ps
`default_nettype none
module ebr_outside_master (
  input wire logic clk_sys_i,
  input wire logic want_i,
  input wire logic bus_ack_n_i,
  output logic ext_bus_request_in_n_o = 1'b1,
  output logic drive_o = 1'b0
);
  always @(posedge clk_sys_i) begin
    drive_o <= want_i && !bus_ack_n_i;
    ext_bus_request_in_n_o <= !(want_i || drive_o);
  end
endmodule // ebr_outside_master
`default_nettype wire

// ### ebr_ext_bus_arbiter_test.sv
`timescale 1ns/100ps
`default_nettype none
module ebr_ext_bus_arbiter_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wbuf = 1'b0;
  logic ilen = 1'b0;
  logic [2:0] ien = 3'h7;
  logic [4:0] arb = 5'h10;
  logic stby = 1'b0;
  logic xreq = 1'b0;
  logic xwr = 1'b0;
  logic want = 1'b0;
  logic [23:0] xaddr = 24'h000000;
  logic [2:0] xarea = 3'h0;
  logic [15:0] xwd = 16'h0000;
  logic [1:0] xbe = 2'h3;
  logic xmode = 1'b1;
  logic ren = 1'b1;
  logic roe = 1'b1;
  wire logic req_n, ack_n, rqo_n, aoe, doe, coe, as_n, cgnt, dgnt, done, rel, sgo;
  wire logic rd_n, hwr_n, lwr_n;
  wire logic [15:0] wdat;
  wire logic [23:0] addr;
  wire logic [7:0] cs_n;
  integer errors = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer seed = 32'hd173a8d1;
  integer n, i, expn;
  integer prev = 0;
  integer parea = 0;
  ebr_ext_bus_arbiter dut_u (.clk_sys_i(clk), .rstn_i(rstn), .expanded_mode_i(xmode),
    .bus_release_en_i(ren), .request_out_en_i(roe), .write_buffer_en_i(wbuf),
    .idle_length_sel_i(ilen), .idle_diff_area_read_en_i(ien[0]),
    .idle_write_after_read_en_i(ien[1]), .idle_read_after_write_en_i(ien[2]),
    .cpu_req_i(arb[4]), .cpu_lock_i(arb[3]), .cpu_sleep_i(arb[2]), .dtc_req_i(arb[1]),
    .dtc_phase_i(arb[0]), .standby_req_i(stby), .xreq_i(xreq), .xwr_i(xwr), .xaddr_i(xaddr),
    .xarea_i(xarea), .xwdata_i(xwd), .xbe_i(xbe), .ext_bus_request_in_n_i(req_n),
    .bus_ack_n_o(ack_n), .bus_request_out_n_o(rqo_n), .addr_o(addr), .addr_oe_o(aoe),
    .data_o(wdat), .data_oe_o(doe), .chip_select_n_o(cs_n), .addr_strobe_n_o(as_n),
    .read_strobe_n_o(rd_n), .high_write_strobe_n_o(hwr_n), .low_write_strobe_n_o(lwr_n),
    .ctrl_oe_o(coe),
    .cpu_gnt_o(cgnt), .dtc_gnt_o(dgnt), .ext_done_o(done), .released_o(rel),
    .standby_go_o(sgo));
  ebr_outside_master far_u (.clk_sys_i(clk), .want_i(want), .bus_ack_n_i(ack_n),
    .ext_bus_request_in_n_o(req_n), .drive_o());
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_done;
    n = 0;
    while (done !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic wait_ack(input logic v);
    n = 0;
    while (ack_n !== v && n < 12) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic edge1;
    @(posedge clk);
    #1;
  endtask
  task automatic access(input logic wr);
    logic idl;
    edge1;
    {ien, ilen, wbuf} = 5'($random(seed));
    xarea = 3'($random(seed));
    xaddr = 24'($random(seed));
    xwd = 16'($random(seed));
    xbe = 2'($random(seed)) | 2'h1;
    xwr = wr;
    idl = (prev == 1 && !wr && parea != xarea && ien[0]) || (prev == 1 && wr && ien[1])
      || (prev == 2 && !wr && ien[2]);
    expn = 3 + (idl ? 1 + ilen : 0) - (wr && wbuf ? 1 : 0);
    edge1;
    xreq = 1'b1;
    wait_done;
    cmp(n, expn);
    cmp(addr, xaddr);
    cmp(cs_n, 8'(~(8'h01 << xarea)));
    cmp({rd_n, hwr_n, lwr_n, doe}, wr ? {1'b1, ~xbe, 1'b1} : 4'h6);
    if (wr) cmp(wdat, xwd);
    edge1;
    xreq = 1'b0;
    prev = wr ? 2 : 1;
    parea = xarea;
  endtask
  task automatic release_test(input logic busy);
    edge1;
    want = 1'b1;
    roe = !busy;
    stby = 1'b1;
    xwr = 1'b0;
    xreq = busy;
    if (!busy) begin
      repeat (2) @(posedge clk);
      edge1;
      xreq = 1'b1;
    end else begin
      wait_done;
      cmp(ack_n, 1'b1);
      edge1;
      xreq = 1'b0;
    end
    wait_ack(1'b0);
    if (!busy) cmp(n < 5, 1'b1);
    cmp({ack_n, aoe, doe, coe, rel}, 5'h01);
    repeat (3) @(negedge clk);
    cmp({done, rqo_n, sgo}, {1'b0, busy, 1'b0});
    edge1;
    want = 1'b0;
    wait_ack(1'b1);
    cmp({rel, sgo}, 2'h1);
    if (!busy) begin
      wait_done;
      cmp(done, 1'b1);
      edge1;
      xreq = 1'b0;
    end
    stby = 1'b0;
    roe = 1'b1;
    prev = !busy;
    parea = xarea;
    $display("release test finished");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 60; i++) access(1'($random(seed)));
    $display("idle test finished");
    release_test(1'b0);
    release_test(1'b1);
    for (i = 0; i < 2; i++) begin
      edge1;
      {xmode, ren} = i ? 2'h2 : 2'h1;
      want = 1'b1;
      repeat (6) @(negedge clk);
      cmp({ack_n, rel}, 2'h2);
      edge1;
      want = 1'b0;
      repeat (4) edge1;
      {xmode, ren} = 2'h3;
    end
    $display("release gate test finished");
    edge1;
    xreq = 1'b1;
    repeat (2) edge1;
    rstn = 1'b0;
    #1;
    cmp({as_n, done, cs_n}, 10'h2FF);
    edge1;
    xreq = 1'b0;
    edge1;
    rstn = 1'b1;
    repeat (3) edge1;
    prev = 0;
    $display("reset test finished");
    for (i = 0; i < 300; i++) begin
      edge1;
      arb = 5'($random(seed));
    end
    arb = 5'h18;
    repeat (4) edge1;
    arb = 5'h1A;
    repeat (3) @(negedge clk);
    cmp({cgnt, dgnt}, 2'h2);
    edge1;
    arb = 5'h12;
    repeat (2) @(negedge clk);
    cmp({cgnt, dgnt}, 2'h1);
    $display("arbitration test finished");
    final_report;
  end
endmodule // ebr_ext_bus_arbiter_test
`default_nettype wire
